// file: common/fsw_defs.svh
// Constants for the serial flash status-write and array-read path.
// Assumes it is included by bare name wherever a constant is needed.
// Functional notes
// - Status write accepted only while the write latch flag is set.
// - Status write changes protect, quad-enable and disable bits, never latch or busy.
// - Status write frame is opcode 01 then one data byte, ended by chip select.
// - Chip select rising off a byte boundary rejects the status write.
// - Self-timed cycle starts at chip select rise; busy stays readable meanwhile.
// - Busy holds for the whole cycle, then busy and write latch clear.
// - Hardware protection rejects status writes even with the latch set.
// - Status writes allowed when disable bit clear, or set with pin high.
// - Hardware protection holds whichever of pin and bit came first.
// - Hardware protection ends when the write-protect pin goes high or a quad mode is entered.
// - Quad command mode or quad-enable disables hardware protection.
// - Programs into the area chosen by the protect bits are refused.
// - Address sampled on rising serial clock, data launched on falling.
// - Plain read is opcode 03 plus 3 address bytes, data until deselect.
// - Read address increments per byte and wraps to 0 at the top.
// - Single-line fast read is 0B, 3 address bytes, one dummy byte.
// - Quad fast read: 2-cycle opcode, 24-bit address, 4 dummy cycles, quad data.
// - Toggling nibbles keep continuous read; non-toggling leave it next frame.
// - Fast read is rejected while a status-write cycle runs.
// - Quad-enable lives in status bit 6, set or cleared by status write.
// - Status-write-disable bit resets to 0.
`ifndef FSW_DEFS_SVH
`define FSW_DEFS_SVH
`define FSW_OP_STATUS_WRITE 8'h01
`define FSW_OP_READ         8'h03
`define FSW_OP_READ_STATUS  8'h05
`define FSW_OP_WRITE_ENABLE 8'h06
`define FSW_OP_FAST_READ    8'h0B
`define FSW_SR_BUSY         0
`define FSW_SR_LATCH        1
`define FSW_SR_BP_LO        2
`define FSW_SR_BP_HI        5
`define FSW_SR_QE           6
`define FSW_SR_STATUS_WRITE_DISABLE_BIT         7
`define FSW_CMD_EDGES_SPI   6'd8
`define FSW_CMD_EDGES_QPI   6'd2
`define FSW_ADDR_EDGES_SPI  6'd24
`define FSW_ADDR_EDGES_QPI  6'd6
`define FSW_DUMMY_EDGES_SPI 6'd8
`define FSW_DUMMY_EDGES_QPI 6'd4
`define FSW_TOGGLE_EDGES    6'd2
`define FSW_BLOCK_BYTES     4096
`define FSW_CLK_PERIOD_NS   100
`define FSW_SW_CYCLE_TIME_NS 5000000
`define FSW_SW_CYCLES ((`FSW_SW_CYCLE_TIME_NS + `FSW_CLK_PERIOD_NS - 1) / `FSW_CLK_PERIOD_NS)
`endif

// file: common/fsw_pkg.sv
// Types shared by the flash status-write and read path.
// Assumes the constants header is available for include.
package fsw_pkg;
    typedef enum logic [2:0] {
        PH_CMD    = 3'b000,
        PH_ADDR   = 3'b001,
        PH_DUMMY  = 3'b010,
        PH_DATA   = 3'b011,
        PH_SWDATA = 3'b100,
        PH_IGNORE = 3'b101
    } fsw_phase_e;

    typedef struct packed {
        logic rst1; logic rst2; logic bsy1; logic bsy2;
        logic wel1; logic wel2; logic qpi1; logic qpi2;
        fsw_phase_e  phase;
        logic        quad;
        logic [7:0]  op;
        logic [7:0]  sh;
        logic [5:0]  cnt;
        logic [5:0]  totCnt;
        logic [23:0] addr;
        logic [7:0]  txByte;
        logic [2:0]  txIdx;
        logic [7:0]  swByte;
        logic        contMode;
    } fsw_link_s;

    typedef struct packed {
        logic cs1; logic cs2; logic csPrev;
        logic wp1; logic wp2; logic qpi1; logic qpi2;
        logic [3:0]  bp;
        logic        qe;
        logic        status_write_disable_bit;
        logic        write_latch_flag;
        logic        busy;
        logic [31:0] timer;
        logic        hardware_protected_mode;
        logic        progRefused;
    } fsw_core_s;
endpackage

// file: verilog/fsw_top.sv
// Serial flash command core: status write with protection modes and array reads.
// Assumes a host drives chip select and serial clock; the testbench resolves the data lines.
`timescale 1ns/1ps
`include "fsw_defs.svh"
module fsw_top #(
    parameter int ADDR_W    = 20,
    parameter int SW_CYCLES = `FSW_SW_CYCLES
) (
    input  wire logic              clk,
    input  wire logic              rst,
    input  wire logic              sclk,
    input  wire logic              csN,
    input  wire logic [3:0]        dataIn,
    output logic      [3:0]        dataOut,
    output logic      [3:0]        dataOeN,
    input  wire logic              quadCmdMode,
    input  wire logic              progReq,
    input  wire logic [ADDR_W-1:0] progAddr,
    input  wire logic [7:0]        progData,
    output logic                   progRefused,
    output logic                   busyFlag,
    output logic                   writeLatchFlag,
    output logic                   hardwareProtectedMode
);
    import fsw_pkg::*;

    localparam int DEPTH = 1 << ADDR_W;

    fsw_link_s  lk;
    fsw_link_s  curLk;
    fsw_link_s  next_lk;
    fsw_core_s  core;
    fsw_core_s  next_core;
    logic       inFrame;
    logic [7:0] mem [DEPTH];
    logic [3:0] nib;
    logic [7:0] shifted;
    logic [5:0] cntInc;
    logic [5:0] cmdEdges;
    logic       byteEnd;
    logic [7:0] statusByte;
    logic       csRise;
    logic       hpmNow;
    logic       isWren;
    logic       isSw;
    logic       swStart;
    logic [31:0] busyLen;

    // Protected span grows downward from the top of the array, doubling per protect level.
    function automatic logic isProtected(input logic [ADDR_W-1:0] a, input logic [3:0] b);
        logic [31:0] span;
        span = 32'(`FSW_BLOCK_BYTES) << (b - 4'h1);
        return (b != 4'h0) && ((span >= 32'(DEPTH)) || (32'(a) >= 32'(DEPTH) - span));
    endfunction

    // The next read address wraps to zero because the array depth is a power of two.
    function automatic logic [23:0] nextAddr(input logic [23:0] a);
        logic [ADDR_W-1:0] low;
        low = a[ADDR_W-1:0] + ADDR_W'(1);
        return 24'(low);
    endfunction

    function automatic logic [5:0] edgesPerByte(input logic quad);
        return quad ? `FSW_CMD_EDGES_QPI : `FSW_CMD_EDGES_SPI;
    endfunction

    // Erased array at start-up; the program port fills it.
    initial begin
        for (int i = 0; i < DEPTH; i++) begin
            mem[i] = 8'hFF;
        end
    end

    // Program writes land only outside the protected span.
    always_ff @(posedge clk) begin
        if (progReq && !isProtected(progAddr, core.bp)) begin
            mem[progAddr] <= progData;
        end
    end

    // Frame marker: cleared by deselect itself, since the serial clock stops between frames.
    always_ff @(posedge sclk or posedge csN) begin
        if (csN) begin
            inFrame <= 1'b0;
        end else begin
            inFrame <= 1'b1;
        end
    end

    // Status byte as the link sees it; upper bits only change under busy, so they are quiet.
    assign statusByte = {core.status_write_disable_bit, core.qe, core.bp, lk.wel2, lk.bsy2};

    // Link-side command decoder, evaluated for each rising serial-clock edge.
    always_comb begin
        curLk = lk;
        if (!inFrame) begin
            curLk.cnt    = 6'd0;
            curLk.totCnt = 6'd0;
            curLk.quad   = lk.contMode | lk.qpi2;
            curLk.op     = lk.contMode ? `FSW_OP_FAST_READ : 8'h00;
            if (lk.contMode) begin
                curLk.phase = lk.bsy2 ? PH_IGNORE : PH_ADDR;
            end else begin
                curLk.phase = PH_CMD;
            end
        end
        nib      = curLk.quad ? dataIn : {3'b000, dataIn[0]};
        shifted  = curLk.quad ? {curLk.sh[3:0], nib} : {curLk.sh[6:0], dataIn[0]};
        cntInc   = curLk.cnt + 6'd1;
        cmdEdges = edgesPerByte(curLk.quad);
        byteEnd  = curLk.quad ? (curLk.txIdx == 3'd1) : (curLk.txIdx == 3'd7);
        next_lk        = curLk;
        next_lk.sh     = shifted;
        next_lk.cnt    = cntInc;
        next_lk.totCnt = (curLk.totCnt == 6'h3F) ? curLk.totCnt : curLk.totCnt + 6'd1;
        next_lk.rst1   = rst;
        next_lk.rst2   = lk.rst1;
        next_lk.bsy1   = core.busy;
        next_lk.bsy2   = lk.bsy1;
        next_lk.wel1   = core.write_latch_flag;
        next_lk.wel2   = lk.wel1;
        next_lk.qpi1   = quadCmdMode;
        next_lk.qpi2   = lk.qpi1;
        case (curLk.phase)
            PH_CMD: begin
                if (cntInc == cmdEdges) begin
                    next_lk.cnt = 6'd0;
                    next_lk.op  = shifted;
                    case (shifted)
                        `FSW_OP_READ: begin
                            next_lk.phase = curLk.quad ? PH_IGNORE : PH_ADDR;
                        end
                        `FSW_OP_FAST_READ: begin
                            next_lk.phase = lk.bsy2 ? PH_IGNORE : PH_ADDR;
                        end
                        `FSW_OP_STATUS_WRITE: begin
                            next_lk.phase = PH_SWDATA;
                        end
                        `FSW_OP_READ_STATUS: begin
                            next_lk.phase  = PH_DATA;
                            next_lk.txByte = statusByte;
                            next_lk.txIdx  = 3'd0;
                        end
                        default: begin
                            next_lk.phase = PH_IGNORE;
                        end
                    endcase
                end
            end
            PH_ADDR: begin
                // Address bits are taken on the rising edge.
                if (curLk.quad) begin
                    next_lk.addr = {curLk.addr[19:0], nib};
                end else begin
                    next_lk.addr = {curLk.addr[22:0], dataIn[0]};
                end
                if (cntInc == (curLk.quad ? `FSW_ADDR_EDGES_QPI : `FSW_ADDR_EDGES_SPI)) begin
                    next_lk.cnt = 6'd0;
                    if (curLk.op == `FSW_OP_READ) begin
                        next_lk.phase  = PH_DATA;
                        next_lk.txByte = mem[next_lk.addr[ADDR_W-1:0]];
                        next_lk.txIdx  = 3'd0;
                    end else begin
                        next_lk.phase = PH_DUMMY;
                    end
                end
            end
            PH_DUMMY: begin
                // The first two quad dummy cycles carry the continuous-read toggle byte.
                if (curLk.quad && cntInc == `FSW_TOGGLE_EDGES) begin
                    next_lk.contMode = (shifted[7:4] == ~shifted[3:0]);
                end
                if (cntInc == (curLk.quad ? `FSW_DUMMY_EDGES_QPI : `FSW_DUMMY_EDGES_SPI)) begin
                    next_lk.cnt    = 6'd0;
                    next_lk.phase  = PH_DATA;
                    next_lk.txByte = mem[curLk.addr[ADDR_W-1:0]];
                    next_lk.txIdx  = 3'd0;
                end
            end
            PH_DATA: begin
                next_lk.txIdx = curLk.txIdx + 3'd1;
                if (byteEnd) begin
                    next_lk.txIdx = 3'd0;
                    if (curLk.op == `FSW_OP_READ_STATUS) begin
                        next_lk.txByte = statusByte;
                    end else begin
                        next_lk.addr   = nextAddr(curLk.addr);
                        next_lk.txByte = mem[next_lk.addr[ADDR_W-1:0]];
                    end
                end
            end
            PH_SWDATA: begin
                if (cntInc == cmdEdges) begin
                    next_lk.swByte = shifted;
                    next_lk.phase  = PH_IGNORE;
                end
            end
            PH_IGNORE: begin
                next_lk.cnt = curLk.cnt;
            end
            default: begin
                next_lk.phase = PH_IGNORE;
            end
        endcase
        if (lk.rst2) begin
            next_lk.contMode = 1'b0;
        end
    end

    // Link state register on the serial clock.
    always_ff @(posedge sclk) begin
        lk <= next_lk;
    end

    // Output drive launched on the falling edge; deselect releases the lines at once.
    always_ff @(negedge sclk or posedge csN) begin
        if (csN) begin
            dataOut <= 4'h0;
            dataOeN <= 4'hF;
        end else if (lk.phase == PH_DATA) begin
            if (lk.quad) begin
                dataOut <= (lk.txIdx == 3'd0) ? lk.txByte[7:4] : lk.txByte[3:0];
                dataOeN <= 4'h0;
            end else begin
                dataOut <= {2'b00, lk.txByte[~lk.txIdx], 1'b0};
                dataOeN <= 4'hD;
            end
        end else begin
            dataOut <= 4'h0;
            dataOeN <= 4'hF;
        end
    end

    // Deselect is seen here only after synchronisation; link fields are still by then.
    assign csRise  = core.cs2 & ~core.csPrev;
    assign hpmNow  = ~core.wp2 & core.status_write_disable_bit & ~core.qe & ~core.qpi2;
    assign isWren  = (lk.op == `FSW_OP_WRITE_ENABLE) && (lk.totCnt == edgesPerByte(lk.quad));
    assign isSw    = (lk.op == `FSW_OP_STATUS_WRITE)
                     && (lk.totCnt == 6'(2 * edgesPerByte(lk.quad)));
    assign swStart = csRise && isSw && core.write_latch_flag && !core.busy && !hpmNow;

    // Status register and self-timed write cycle on the system clock.
    always_comb begin
        next_core        = core;
        next_core.cs1    = csN;
        next_core.cs2    = core.cs1;
        next_core.csPrev = core.cs2;
        next_core.wp1    = dataIn[2];
        next_core.wp2    = core.wp1;
        next_core.qpi1   = quadCmdMode;
        next_core.qpi2   = core.qpi1;
        next_core.hardware_protected_mode    = hpmNow;
        next_core.progRefused = progReq && isProtected(progAddr, core.bp);
        if (csRise && isWren && !core.busy) begin
            next_core.write_latch_flag = 1'b1;
        end
        if (swStart) begin
            next_core.bp    = lk.swByte[`FSW_SR_BP_HI:`FSW_SR_BP_LO];
            next_core.qe    = lk.swByte[`FSW_SR_QE];
            next_core.status_write_disable_bit  = lk.swByte[`FSW_SR_STATUS_WRITE_DISABLE_BIT];
            next_core.busy  = 1'b1;
            next_core.timer = 32'(SW_CYCLES - 1);
        end else if (core.busy) begin
            if (core.timer == 32'h0) begin
                next_core.busy = 1'b0;
                next_core.write_latch_flag  = 1'b0;
            end else begin
                next_core.timer = core.timer - 32'h1;
            end
        end
        if (rst) begin
            next_core      = '0;
            next_core.cs1  = 1'b1;
            next_core.cs2  = 1'b1;
            next_core.csPrev = 1'b1;
            next_core.status_write_disable_bit = 1'b0;
        end
    end

    // Core state register.
    always_ff @(posedge clk) begin
        core <= next_core;
    end

    // Length of the current busy stretch, read only by the checks below.
    always_ff @(posedge clk) begin
        if (rst || !core.busy) begin
            busyLen <= 32'h0;
        end else begin
            busyLen <= busyLen + 32'h1;
        end
    end

    assign progRefused           = core.progRefused;
    assign busyFlag              = core.busy;
    assign writeLatchFlag        = core.write_latch_flag;
    assign hardwareProtectedMode = core.hardware_protected_mode;

    sequence swCmdAccepted;
        csRise && isSw && core.write_latch_flag && !core.busy && !hpmNow;
    endsequence

    a_sw_needs_latch: assert property (@(posedge clk) disable iff (rst)
        (csRise && isSw && !core.write_latch_flag) |=> !core.busy)
        else $error("status write accepted without the write latch");
    a_sw_field_update: assert property (@(posedge clk) disable iff (rst)
        swCmdAccepted |=> core.write_latch_flag && core.busy && (core.bp == $past(lk.swByte[5:2])))
        else $error("status write fields or latch wrong");
    a_bad_boundary: assert property (@(posedge clk) disable iff (rst)
        (csRise && lk.op == `FSW_OP_STATUS_WRITE && !isSw && !core.busy)
        |=> !core.busy && $stable(core.bp) && $stable(core.status_write_disable_bit))
        else $error("status write off a byte boundary was executed");
    a_busy_length: assert property (@(posedge clk) disable iff (rst)
        $fell(core.busy) |-> !core.write_latch_flag && ($past(busyLen) == 32'(SW_CYCLES - 1)))
        else $error("status write cycle length or latch clear wrong");
    a_hpm_freeze: assert property (@(posedge clk) disable iff (rst)
        (csRise && hpmNow) |=> $stable(core.bp) && $stable(core.status_write_disable_bit) && $stable(core.busy))
        else $error("status write executed under hardware protection");
    a_quad_no_hpm: assert property (@(posedge clk) disable iff (rst)
        (core.qe || core.qpi2) |=> !core.hardware_protected_mode)
        else $error("hardware protection active in quad mode");
    a_prog_refused: assert property (@(posedge clk) disable iff (rst)
        (progReq && core.bp == 4'hF) |=> core.progRefused)
        else $error("program into a fully protected array not refused");
    a_oe_released: assert property (@(posedge clk) disable iff (rst)
        core.cs2 |-> (dataOeN == 4'hF))
        else $error("data lines driven while deselected");
    a_read_wrap: assert property (@(posedge sclk) disable iff (csN)
        (lk.phase == PH_DATA && lk.op != `FSW_OP_READ_STATUS
         && (lk.quad ? lk.txIdx == 3'd1 : lk.txIdx == 3'd7))
        |=> !inFrame || (lk.addr == nextAddr($past(lk.addr))))
        else $error("read address did not advance or wrap");
endmodule

// file: dv/fsw_host_model.sv
// Host-side model of a serial flash controller: chip select, sclk and data lines.
// Assumes the device drives dataOut/dataOeN; sclk stands still outside frames.
`timescale 1ns/1ps
module fsw_host_model (
    output logic            sclk,
    output logic            csN,
    output wire logic [3:0] dataIn,
    input  wire logic [3:0] dataOut,
    input  wire logic [3:0] dataOeN,
    input  wire logic       wpPin
);
    logic [3:0] hostVal;
    logic [3:0] lastOe;
    logic       qNow;
    logic [3:0] drv;

    // In single-line mode line 2 is the write-protect pin and line 3 is pulled up.
    assign drv    = qNow ? hostVal : {1'b1, wpPin, hostVal[1:0]};
    // Each line shows the device where it drives, otherwise the host value.
    assign dataIn = (~dataOeN & dataOut) | (dataOeN & drv);

    initial begin
        sclk    = 1'b0;
        csN     = 1'b1;
        hostVal = 4'hB;
        lastOe  = 4'hF;
        qNow    = 1'b0;
    end

    // One frame: send n edges MSB first, then clock in nRd bytes, then deselect.
    task automatic xfer(input logic [63:0] tx, input int n, input bit q, input int nRd,
                        output logic [63:0] rx);
        int w;
        w    = q ? 4 : 1;
        qNow = q;
        rx   = '0;
        csN  = 1'b0;
        #20;
        for (int i = n - 1; i >= 0; i--) begin
            if (q) begin
                hostVal = tx[4*i +: 4];
            end else begin
                hostVal[0] = tx[i];
            end
            #32 sclk = 1'b1;
            #32 sclk = 1'b0;
        end
        // Released lines show the inverse, so a stale copy can never pass for data.
        hostVal = ~hostVal;
        for (int i = 0; i < nRd * 8 / w; i++) begin
            #32 sclk = 1'b1;
            rx     = q ? {rx[59:0], dataOut} : {rx[62:0], dataOut[1]};
            lastOe = dataOeN;
            #32 sclk = 1'b0;
        end
        #32 csN = 1'b1;
        #500;
    endtask
endmodule

// file: dv/tb_flash_status_write_and_read_path.sv
// Self-checking bench for the flash status-write and array-read path.
// Assumes the host model is compiled first; frames run on its own sclk.
`timescale 1ns/1ps
module tb_flash_status_write_and_read_path;
    import fsw_pkg::*;
    localparam int AW  = 8;
    localparam int SWC = 100;
    logic          clk;
    logic          rst;
    logic          sclk;
    logic          csN;
    wire  [3:0]    dataIn;
    logic [3:0]    dataOut;
    logic [3:0]    dataOeN;
    logic          quadCmdMode;
    logic          progReq;
    logic [AW-1:0] progAddr;
    logic [7:0]    progData;
    logic          progRefused;
    logic          busyFlag;
    logic          writeLatchFlag;
    logic          hardwareProtectedMode;
    logic          wp;
    logic [63:0]   rx;
    int            err_count;
    int            samples_checked;
    int            busyCnt;

    fsw_top #(.ADDR_W(AW), .SW_CYCLES(SWC)) u_fsw_top (
        .clk(clk), .rst(rst), .sclk(sclk), .csN(csN), .dataIn(dataIn),
        .dataOut(dataOut), .dataOeN(dataOeN), .quadCmdMode(quadCmdMode),
        .progReq(progReq), .progAddr(progAddr), .progData(progData),
        .progRefused(progRefused), .busyFlag(busyFlag),
        .writeLatchFlag(writeLatchFlag), .hardwareProtectedMode(hardwareProtectedMode));

    fsw_host_model u_fsw_host_model (
        .sclk(sclk), .csN(csN), .dataIn(dataIn), .dataOut(dataOut),
        .dataOeN(dataOeN), .wpPin(wp));

    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    // Counts clk cycles with busy high, so the cycle length is judged exactly.
    always @(posedge clk) begin
        if (busyFlag === 1'b1) begin
            busyCnt <= busyCnt + 1;
        end
    end

    task automatic chk_val(input string what, input logic [63:0] exp, input logic [63:0] got);
        samples_checked++;
        if (got !== exp) begin
            err_count++;
            $display("BAD %s expected %0h seen %0h", what, exp, got);
        end
    endtask

    task automatic chk_flag(input string what, input logic exp, input logic got);
        samples_checked++;
        if (got !== exp) begin
            err_count++;
            $display("BAD %s expected %b seen %b", what, exp, got);
        end
    endtask

    task automatic finish_test;
        $display("Comparisons %0d, mismatches %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    task automatic frame(input logic [63:0] tx, input int n, input bit q, input int nRd);
        u_fsw_host_model.xfer(tx, n, q, nRd, rx);
    endtask

    task automatic chk_sr(input logic [7:0] exp);
        frame(64'h05, 8, 0, 1);
        chk_val("status", {56'h0, exp}, rx);
    endtask

    task automatic settle(input int n);
        repeat (n) @(negedge clk);
    endtask

    // Bounded wait for the self-timed cycle to end; a hang shows as a mismatch.
    task automatic wait_idle;
        int k;
        k = 0;
        while (busyFlag !== 1'b0 && k < 300) begin
            @(negedge clk);
            k++;
        end
        chk_flag("idle", 1'b0, busyFlag);
    endtask

    task automatic prog(input logic [7:0] a, input logic [7:0] d, input logic refused);
        @(negedge clk);
        progAddr = a;
        progData = d;
        progReq  = 1'b1;
        @(negedge clk);
        progReq = 1'b0;
        chk_flag("refused", refused, progRefused);
    endtask

    task automatic t_reset;
        chk_flag("busy", 1'b0, busyFlag);
        chk_val("oe", 4'hF, dataOeN);
        chk_sr(8'h00);
    endtask

    task automatic t_latch_guard;
        frame({8'h01, 8'h3C}, 16, 0, 0);
        chk_sr(8'h00);
        frame(64'h06, 8, 0, 0);
        chk_flag("latch", 1'b1, writeLatchFlag);
        frame({8'h01, 7'h1E}, 15, 0, 0);
        chk_flag("busy", 1'b0, busyFlag);
        chk_sr(8'h02);
    endtask

    // Written low bits are 11 and must not reach latch or busy.
    task automatic t_write_cycle;
        busyCnt = 0;
        frame({8'h01, 8'h0F}, 16, 0, 0);
        chk_flag("busy", 1'b1, busyFlag);
        chk_sr(8'h0F);
        frame({8'h0B, 32'h0}, 40, 0, 1);
        chk_val("oe", 4'hF, u_fsw_host_model.lastOe);
        wait_idle();
        chk_val("busy span", SWC, busyCnt);
        chk_flag("latch", 1'b0, writeLatchFlag);
        chk_sr(8'h0C);
    endtask

    // Protect bits 3 cover the whole small array, so any program is refused.
    task automatic t_prog_read;
        prog(8'h10, 8'h00, 1'b1);
        frame(64'h06, 8, 0, 0);
        frame({8'h01, 8'h00}, 16, 0, 0);
        wait_idle();
        prog(8'hFE, 8'h5A, 1'b0);
        prog(8'hFF, 8'hC3, 1'b0);
        prog(8'h00, 8'h96, 1'b0);
        frame({8'h03, 24'hFE}, 32, 0, 3);
        chk_val("read", 24'h5AC396, rx);
        chk_val("oe", 4'hD, u_fsw_host_model.lastOe);
        frame({8'h0B, 24'hFF, 8'h00}, 40, 0, 2);
        chk_val("fast", 16'hC396, rx);
        chk_val("oe", 4'hF, dataOeN);
    endtask

    task automatic t_quad;
        @(negedge clk);
        quadCmdMode = 1'b1;
        settle(10);
        // The link side only sees the new mode after two serial clocks, so an ignored frame goes first.
        frame(64'hFF, 8, 0, 0);
        frame({8'h0B, 24'hFE, 8'hA5, 8'h00}, 12, 1, 2);
        chk_val("quad", 16'h5AC3, rx);
        chk_val("oe", 4'h0, u_fsw_host_model.lastOe);
        frame({24'hFF, 8'hFF, 8'h00}, 10, 1, 1);
        chk_val("cont", 8'hC3, rx);
        frame({8'h0B, 24'h00, 16'h0}, 12, 1, 1);
        chk_val("quad", 8'h96, rx);
        @(negedge clk);
        quadCmdMode = 1'b0;
        settle(10);
        frame(64'hFF, 2, 1, 0);
    endtask

    task automatic t_protect_modes;
        frame(64'h06, 8, 0, 0);
        frame({8'h01, 8'h80}, 16, 0, 0);
        wait_idle();
        wp = 1'b0;
        settle(5);
        chk_flag("hpm", 1'b1, hardwareProtectedMode);
        quadCmdMode = 1'b1;
        settle(5);
        chk_flag("hpm", 1'b0, hardwareProtectedMode);
        quadCmdMode = 1'b0;
        settle(10);
        frame(64'h06, 8, 0, 0);
        frame({8'h01, 8'h00}, 16, 0, 0);
        chk_flag("busy", 1'b0, busyFlag);
        chk_sr(8'h82);
        wp = 1'b1;
        settle(5);
        chk_flag("hpm", 1'b0, hardwareProtectedMode);
        frame({8'h01, 8'h00}, 16, 0, 0);
        wait_idle();
        chk_sr(8'h00);
        wp = 1'b0;
        frame(64'h06, 8, 0, 0);
        frame({8'h01, 8'h80}, 16, 0, 0);
        wait_idle();
        chk_sr(8'h80);
        chk_flag("hpm", 1'b1, hardwareProtectedMode);
    endtask

    // Watchdog: the run needs well under half this span.
    initial begin
        #1000000;
        err_count++;
        finish_test();
    end

    initial begin
        err_count       = 0;
        samples_checked = 0;
        busyCnt         = 0;
        rst             = 1'b1;
        wp              = 1'b1;
        quadCmdMode     = 1'b0;
        progReq         = 1'b0;
        progAddr        = 8'h00;
        progData        = 8'h00;
        // The link flops have no reset of their own: a throw-away frame during reset
        // lets them see it through their synchroniser and clears continuous-read mode.
        fork
            begin
                @(negedge clk);
                frame(64'hFF, 8, 0, 0);
            end
            begin
                repeat (3) @(negedge clk);
                rst = 1'b0;
            end
        join
        settle(3);
        t_reset();
        t_latch_guard();
        t_write_cycle();
        t_prog_read();
        t_quad();
        t_protect_modes();
        finish_test();
    end
endmodule
